// ===== design/srstc_pkg.sv
// Purpose: shared constants and types of the system reset controller
// Assumes: 125 MHz cpu clock; one half period counts as half a clock cycle
// Notes: all timing counts are derived here from the printed figures
package srstc_pkg;

  // ----------------------------------------------------------------
  // clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  // half periods to cycles, rounded up so no interval is shortened
  function automatic int tcl_to_cyc(input int half_cpu_period);
    return (half_cpu_period + 1) / 2;
  endfunction
  function automatic int ns_to_cyc_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // ----------------------------------------------------------------
  // input filter and pulse classes
  // ----------------------------------------------------------------
  localparam int FILTER_REJECT_NS = 50;
  localparam int FILTER_CYC = ns_to_cyc_min(FILTER_REJECT_NS);
  localparam int VALID_PULSE_NS = 500;
  localparam int MIN_PULSE_TCL = 4;
  localparam int MIN_PULSE_CYC = (tcl_to_cyc(MIN_PULSE_TCL) > ns_to_cyc_min(VALID_PULSE_NS))
                                 ? tcl_to_cyc(MIN_PULSE_TCL) : ns_to_cyc_min(VALID_PULSE_NS);
  localparam int LONG_BASE_TCL = 1032;
  localparam int LONG_EXTRA_TCL = 12;
  localparam int LONG_CYC = tcl_to_cyc(LONG_BASE_TCL + LONG_EXTRA_TCL) + MIN_PULSE_CYC;

  // ----------------------------------------------------------------
  // sequence timing
  // ----------------------------------------------------------------
  localparam int SYNC_DLY_TCL = 12;
  localparam int SYNC_SEQ_TCL = 1024;
  localparam int SAMPLE_TCL = 8;
  localparam int EXT_REL_TCL = 8;
  localparam int SYNC_DLY_CYC = tcl_to_cyc(SYNC_DLY_TCL);
  localparam int SYNC_SEQ_CYC = tcl_to_cyc(SYNC_SEQ_TCL);
  localparam int SAMPLE_CYC = tcl_to_cyc(SAMPLE_TCL);
  localparam int EXT_REL_CYC = tcl_to_cyc(EXT_REL_TCL);
  localparam int FLASH_INIT_NS = 1000000;
  localparam int FLASH_INIT_CYC = FLASH_INIT_NS / CLK_PERIOD_NS;
  localparam int FLASH_EARLY_CYC = 64;
  localparam logic [15:0] FLASH_EARLY_DATA = 16'hffff;
  localparam logic [15:0] FLASH_LATE_DATA = 16'h009b;
  localparam logic [23:0] START_ADDR = 24'h00_0000;

  // ----------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CONFIG = 8'h08;
  localparam int CTRL_BIDIR_BIT = 0;
  localparam int FLAG_PON_BIT = 0;
  localparam int FLAG_LONG_BIT = 1;
  localparam int FLAG_SHORT_BIT = 2;
  localparam int FLAG_WDT_BIT = 3;
  localparam int FLAG_SW_BIT = 4;
  localparam int FLAG_W = 5;
  localparam int STATE_LSB = 8;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 5'h01;

  // ----------------------------------------------------------------
  // sequencer states and reset sources
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_ASYNC = 4'b0001,
    ST_DLY   = 4'b0010,
    ST_SEQ   = 4'b0011,
    ST_SAMP  = 4'b0100,
    ST_WREL  = 4'b0101,
    ST_FLASH = 4'b0110,
    ST_EXT   = 4'b0111,
    ST_RUN   = 4'b1000
  } srstc_state_t;

  typedef enum logic [1:0] {
    SRC_HW  = 2'b00,
    SRC_WDT = 2'b01,
    SRC_SW  = 2'b10
  } srstc_src_t;

endpackage

// ===== design/srstc_sync.sv
// Purpose: three-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk
// Notes: output moves only once stages two and three agree
`timescale 1ns/1ps
module srstc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q, out_d;

  // ----------------------------------------------------------------
  // agreement of later stages; first stage feeds stage two only
  // ----------------------------------------------------------------
  always_comb begin
    out_d = out_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  // stage registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      out_q <= INIT;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign level_out = out_q;
endmodule

// ===== design/srstc_top.sv
// Purpose: system reset sequencer with source flags and wishbone registers
// Assumes: reset_n is the power-on reset and needs no running clock
// Notes: half periods map to half clock cycles, rounded up
//
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
module srstc_top
  import srstc_pkg::*;
#(
  parameter int FLASH_INIT_CYCLES = srstc_pkg::FLASH_INIT_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic reset_request_in_n,
  output logic reset_request_out,
  output logic reset_request_oe,
  input wire logic reset_mode_select_pin,
  input wire logic external_boot_select_n,
  input wire logic [15:0] configuration_port,
  input wire logic flash_init_done,
  input wire logic watchdog_overflow,
  input wire logic software_reset_instruction,
  input wire logic end_of_init_instruction,
  output logic reset_indication_out_n,
  output logic core_reset_n,
  output logic hold_cancel,
  output logic bus_abort,
  output logic bus_tristate,
  output logic config_port_pullup,
  output logic strobes_inactive,
  output logic [15:0] system_config_register,
  output logic [23:0] fetch_address,
  output logic [15:0] flash_read_data
);
  import srstc_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic req_sync_n, mode_sync, boot_sync_n;
  logic [15:0] cfg_sync;

  srstc_sync #(.WIDTH(3), .INIT(3'b111)) u_pins (
    .clk(clk),
    .reset_n(reset_n),
    .pin_in({reset_request_in_n, reset_mode_select_pin, external_boot_select_n}),
    .level_out({req_sync_n, mode_sync, boot_sync_n})
  );

  srstc_sync #(.WIDTH(16), .INIT(16'hffff)) u_cfg (
    .clk(clk),
    .reset_n(reset_n),
    .pin_in(configuration_port),
    .level_out(cfg_sync)
  );

  // ----------------------------------------------------------------
  // request qualifier
  // ----------------------------------------------------------------
  localparam logic [3:0] FILT_MAX = 4'(FILTER_CYC);
  logic [3:0] filt_cnt_q, filt_cnt_d;
  logic req_q, req_d;

  // low only after FILTER_CYC+1 agreeing samples; spikes never reach the fsm
  always_comb begin
    filt_cnt_d = filt_cnt_q;
    req_d = req_q;
    if (req_sync_n) begin
      filt_cnt_d = '0;
      req_d = 1'b0;
    end else if (filt_cnt_q != FILT_MAX) begin
      filt_cnt_d = filt_cnt_q + 4'd1;
    end else begin
      req_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      filt_cnt_q <= '0;
      req_q <= 1'b0;
    end else begin
      filt_cnt_q <= filt_cnt_d;
      req_q <= req_d;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  localparam logic [19:0] DLY_END = 20'(SYNC_DLY_CYC - 1);
  localparam logic [19:0] SEQ_END = 20'(SYNC_SEQ_CYC - 1);
  localparam logic [19:0] SAMP_END = 20'(SAMPLE_CYC - 1);
  localparam logic [19:0] EXT_END = 20'(EXT_REL_CYC - 1);
  localparam logic [19:0] EARLY_END = 20'(FLASH_EARLY_CYC);
  localparam logic [11:0] LONG_LIM = 12'(LONG_CYC);

  srstc_state_t state_q, state_d;
  srstc_src_t src_q, src_d;
  logic [19:0] cnt_q, cnt_d;
  logic [11:0] low_q, low_d;
  logic [FLAG_W-1:0] flag_q, flag_d;
  logic bidir_q, bidir_d;
  logic [15:0] cfg_q, cfg_d;
  logic set_long, set_short, leave_seq;
  logic bus_wr_ctrl;

  // exit path after release: flash boot waits init, external boot is quick
  function automatic srstc_state_t exit_state(input logic ext_n);
    return ext_n ? ST_FLASH : ST_EXT;
  endfunction

  always_comb begin
    state_d = state_q;
    src_d = src_q;
    cnt_d = cnt_q + 20'd1;
    low_d = low_q;
    set_long = 1'b0;
    set_short = 1'b0;
    leave_seq = 1'b0;
    cfg_d = cfg_q;
    // width of the hardware request, saturating above the long limit
    if (req_q && src_q == SRC_HW && low_q <= LONG_LIM) begin
      low_d = low_q + 12'd1;
    end
    case (state_q)
      ST_IDLE, ST_RUN: begin
        cnt_d = '0;
        if (req_q && !mode_sync) begin
          state_d = ST_ASYNC;
        end else if (req_q) begin
          state_d = ST_DLY;
          src_d = SRC_HW;
          low_d = 12'(FILTER_CYC);
        end else if (state_q == ST_RUN && watchdog_overflow) begin
          state_d = ST_DLY;
          src_d = SRC_WDT;
        end else if (state_q == ST_RUN && software_reset_instruction) begin
          state_d = ST_DLY;
          src_d = SRC_SW;
        end
      end
      ST_ASYNC: begin
        cnt_d = '0;
        if (!req_q) begin
          state_d = exit_state(boot_sync_n);
        end
      end
      ST_DLY, ST_SEQ, ST_SAMP: begin
        if (src_q == SRC_HW && req_q && !mode_sync) begin
          state_d = ST_ASYNC;
          cnt_d = '0;
        end else if (state_q == ST_DLY && cnt_q == DLY_END) begin
          state_d = ST_SEQ;
          cnt_d = '0;
        end else if (state_q == ST_SEQ && cnt_q == SEQ_END) begin
          state_d = ST_SAMP;
          cnt_d = '0;
        end else if (state_q == ST_SAMP && cnt_q == SAMP_END) begin
          state_d = ST_WREL;
          cnt_d = '0;
        end
      end
      ST_WREL: begin
        cnt_d = '0;
        if (!req_q) begin
          state_d = exit_state(boot_sync_n);
          if (src_q == SRC_HW) begin
            set_long = (low_q > LONG_LIM);
            set_short = (low_q <= LONG_LIM);
          end
        end
      end
      ST_FLASH: begin
        if (req_q) begin
          state_d = ST_IDLE;
        end else if (flash_init_done || cnt_q == 20'(FLASH_INIT_CYCLES - 1)) begin
          state_d = ST_RUN;
          leave_seq = 1'b1;
        end
      end
      ST_EXT: begin
        if (req_q) begin
          state_d = ST_IDLE;
        end else if (cnt_q == EXT_END) begin
          state_d = ST_RUN;
          leave_seq = 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d = '0;
      end
    endcase
    if (leave_seq) begin
      cfg_d = cfg_sync;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      src_q <= SRC_HW;
      cnt_q <= '0;
      low_q <= '0;
      cfg_q <= '0;
    end else begin
      state_q <= state_d;
      src_q <= src_d;
      cnt_q <= cnt_d;
      low_q <= low_d;
      cfg_q <= cfg_d;
    end
  end

  // ----------------------------------------------------------------
  // source flags and bidirectional enable
  // ----------------------------------------------------------------
  // flag sets win over a clear in the same cycle
  always_comb begin
    flag_d = flag_q;
    if (end_of_init_instruction) begin
      flag_d = '0;
    end
    if (set_long) begin
      flag_d[FLAG_LONG_BIT] = 1'b1;
      flag_d[FLAG_SHORT_BIT] = 1'b1;
    end
    if (set_short) begin
      flag_d[FLAG_SHORT_BIT] = 1'b1;
    end
    if (leave_seq && src_q == SRC_WDT) begin
      flag_d[FLAG_WDT_BIT] = 1'b1;
    end
    if (leave_seq && src_q == SRC_SW) begin
      flag_d[FLAG_SW_BIT] = 1'b1;
    end
    bidir_d = bidir_q;
    if (bus_wr_ctrl) begin
      bidir_d = wb_dat_i[CTRL_BIDIR_BIT];
    end
    if (leave_seq || state_q == ST_ASYNC) begin
      bidir_d = 1'b0;
    end
  end

  // power-on flag is the reset value; reset_n needs no clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_q <= FLAG_RESET;
      bidir_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      bidir_q <= bidir_d;
    end
  end

  // ----------------------------------------------------------------
  // pin and core outputs, registered except the constant request level and fetch address
  // ----------------------------------------------------------------
  logic in_async, in_seq, run_d, pull_d;
  logic [15:0] fdata_d;

  always_comb begin
    // entry from idle or run counts at once, so abort and hold cancel do not lag
    in_async = (state_q == ST_ASYNC)
               || ((state_q == ST_IDLE || state_q == ST_RUN) && req_q && !mode_sync);
    in_seq = (state_q == ST_DLY) || (state_q == ST_SEQ);
    run_d = (state_d == ST_RUN);
    // pull-down only for soft events, and never while mode pin is low
    pull_d = bidir_q && mode_sync && in_seq && (src_q != SRC_HW);
    fdata_d = (cnt_q < EARLY_END) ? FLASH_EARLY_DATA : FLASH_LATE_DATA;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_indication_out_n <= 1'b0;
      core_reset_n <= 1'b0;
      hold_cancel <= 1'b1;
      bus_abort <= 1'b1;
      bus_tristate <= 1'b1;
      config_port_pullup <= 1'b1;
      strobes_inactive <= 1'b1;
      reset_request_oe <= 1'b0;
      flash_read_data <= FLASH_EARLY_DATA;
    end else begin
      reset_indication_out_n <= run_d;
      core_reset_n <= run_d;
      hold_cancel <= in_async || in_seq;
      bus_abort <= in_async;
      bus_tristate <= !run_d;
      config_port_pullup <= in_async || (state_d == ST_ASYNC);
      strobes_inactive <= !run_d || leave_seq;
      reset_request_oe <= pull_d;
      flash_read_data <= fdata_d;
    end
  end

  assign reset_request_out = 1'b0; // open drain, only low is driven
  assign system_config_register = cfg_q;
  assign fetch_address = START_ADDR;

  // ----------------------------------------------------------------
  // wishbone slave, one wait state, unmapped reads return zero
  // ----------------------------------------------------------------
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;

  always_comb begin
    ack_d = wb_cyc_i && wb_stb_i && !ack_q;
    // write lands on the edge at which the master sees ack high
    bus_wr_ctrl = ack_q && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
                  && (wb_adr_i == ADDR_CTRL);
    rdat_d = '0;
    case (wb_adr_i)
      ADDR_CTRL: rdat_d[CTRL_BIDIR_BIT] = bidir_q;
      ADDR_STATUS: begin
        rdat_d[FLAG_W-1:0] = flag_q;
        rdat_d[STATE_LSB +: 4] = state_q;
      end
      ADDR_CONFIG: rdat_d[15:0] = cfg_q;
      default: rdat_d = '0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
endmodule

// ===== dv/srstc_top_asserts.sv
// Purpose: port-level checker for srstc_top
// Assumes: mode pin is held steady while the core runs
// Notes: bound into srstc_top at the foot of this file
`timescale 1ns/1ps
module srstc_top_chk
  import srstc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_ack_o,
  input wire logic reset_request_in_n,
  input wire logic reset_request_oe,
  input wire logic reset_mode_select_pin,
  input wire logic external_boot_select_n,
  input wire logic reset_indication_out_n,
  input wire logic core_reset_n,
  input wire logic hold_cancel,
  input wire logic bus_abort,
  input wire logic bus_tristate,
  input wire logic config_port_pullup,
  input wire logic [15:0] system_config_register,
  input wire logic [23:0] fetch_address
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ----------------
  // helper: cycles spent in reset
  // ----------------
  logic [11:0] low_cnt_q;
  logic [11:0] low_cnt_d;
  // wide enough for the longest reset the bench makes
  always_comb begin
    low_cnt_d = reset_indication_out_n ? 12'h000 : low_cnt_q + 12'h001;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt_q <= 12'h000;
    end else begin
      low_cnt_q <= low_cnt_d;
    end
  end
  // ----------------
  // properties
  // ----------------
  sequence req_low_async;
    (!reset_request_in_n && !reset_mode_select_pin) [*8];
  endsequence
  sequence req_low_sync;
    (!reset_request_in_n && reset_mode_select_pin) [*8];
  endsequence
  chk_async_entry: assert property (req_low_async |-> ##[0:8] !reset_indication_out_n)
    else $error("async request not taken");
  chk_sync_entry: assert property (req_low_sync |-> ##[0:8] !reset_indication_out_n)
    else $error("sync request not taken");
  chk_async_drive: assert property ($fell(reset_indication_out_n) && !reset_request_in_n
    && !reset_mode_select_pin |-> ##[0:2] (hold_cancel && bus_abort && bus_tristate
    && config_port_pullup)) else $error("async reset outputs not driven");
  chk_ext_release: assert property ($rose(reset_request_in_n) && !reset_mode_select_pin
    && !external_boot_select_n && !reset_indication_out_n |-> ##[1:24] core_reset_n)
    else $error("external boot release late");
  chk_sync_length: assert property ($rose(reset_indication_out_n) && reset_mode_select_pin
    |-> low_cnt_q >= 12'(SYNC_SEQ_CYC)) else $error("sync sequence too short");
  chk_oe_mode_high: assert property (reset_request_oe |-> reset_mode_select_pin)
    else $error("pin pulled with mode low");
  chk_fetch_zero: assert property (fetch_address == 24'h00_0000)
    else $error("start address not zero");
  chk_cfg_stable: assert property (core_reset_n && $past(core_reset_n)
    && $past(core_reset_n, 2) |-> $stable(system_config_register))
    else $error("config changed while running");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule

bind srstc_top srstc_top_chk u_chk (.clk(clk), .reset_n(reset_n), .wb_ack_o(wb_ack_o),
  .reset_request_in_n(reset_request_in_n), .reset_request_oe(reset_request_oe),
  .reset_mode_select_pin(reset_mode_select_pin), .external_boot_select_n(external_boot_select_n),
  .reset_indication_out_n(reset_indication_out_n), .core_reset_n(core_reset_n),
  .hold_cancel(hold_cancel), .bus_abort(bus_abort), .bus_tristate(bus_tristate),
  .config_port_pullup(config_port_pullup), .system_config_register(system_config_register),
  .fetch_address(fetch_address));

// ===== dv/srstc_supervisor.sv
// Purpose: reset supervisor and strap pins facing srstc_top
// Assumes: request pin is open drain with a pull-up
// Notes: power-on hold is scaled down to cycles
`timescale 1ns/1ps
module srstc_supervisor #(
  parameter int POWER_HOLD_CYC = 40
) (
  input wire logic clk,
  output logic req_drive_n,
  output logic mode_level,
  output logic boot_sel_n,
  output logic [15:0] straps
);
  // ----------------
  // pins at power-on: request, mode and boot select all low; power_release raises only request, once clock and straps settle
  // ----------------
  initial begin
    req_drive_n = 1'b0;
    mode_level = 1'b0;
    boot_sel_n = 1'b0;
    straps = 16'ha5c3;
  end
  // hold stands in for oscillator, pll and regulator start
  task automatic power_release();
    repeat (POWER_HOLD_CYC) @(posedge clk);
    req_drive_n <= 1'b1;
  endtask
  // request pulse; very short ones are deliberate glitches
  task automatic hold_request(input logic mode, input int cyc);
    @(posedge clk);
    mode_level <= mode;
    req_drive_n <= 1'b0;
    repeat (cyc) @(posedge clk);
    req_drive_n <= 1'b1;
  endtask
  task automatic set_pins(input logic mode, input logic boot_n, input logic [15:0] cfg);
    @(posedge clk);
    mode_level <= mode;
    boot_sel_n <= boot_n;
    straps <= cfg;
  endtask
endmodule

// ===== dv/test_system_reset_controller.sv
// Purpose: self-checking bench for srstc_top
// Assumes: flash wait shortened to 200 cycles
// Notes: partner model drives request, mode and strap pins
`timescale 1ns/1ps
module test_system_reset_controller;
  import srstc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_ack_o;
  logic flash_init_done = 1'b0;
  logic watchdog_overflow = 1'b0;
  logic software_reset_instruction = 1'b0;
  logic end_of_init_instruction = 1'b0;
  logic req_drive_n, req_pin_n, reset_request_out, reset_request_oe, mode_level, boot_sel_n;
  logic reset_indication_out_n, core_reset_n, hold_cancel, bus_abort, bus_tristate;
  logic config_port_pullup, strobes_inactive;
  logic [15:0] straps, system_config_register, flash_read_data;
  logic [23:0] fetch_address;
  int mismatches = 0;
  int checks_done = 0;
  // open-drain request pin: either party can pull it low
  assign req_pin_n = req_drive_n & ~(reset_request_oe & ~reset_request_out);
  always #4 clk = ~clk;
  srstc_supervisor #(.POWER_HOLD_CYC(40)) sup (.clk(clk), .req_drive_n(req_drive_n),
    .mode_level(mode_level), .boot_sel_n(boot_sel_n), .straps(straps));
  srstc_top #(.FLASH_INIT_CYCLES(200)) dut (.clk(clk), .reset_n(reset_n),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .reset_request_in_n(req_pin_n), .reset_request_out(reset_request_out),
    .reset_request_oe(reset_request_oe), .reset_mode_select_pin(mode_level),
    .external_boot_select_n(boot_sel_n), .configuration_port(straps),
    .flash_init_done(flash_init_done), .watchdog_overflow(watchdog_overflow),
    .software_reset_instruction(software_reset_instruction),
    .end_of_init_instruction(end_of_init_instruction),
    .reset_indication_out_n(reset_indication_out_n), .core_reset_n(core_reset_n),
    .hold_cancel(hold_cancel), .bus_abort(bus_abort), .bus_tristate(bus_tristate),
    .config_port_pullup(config_port_pullup), .strobes_inactive(strobes_inactive),
    .system_config_register(system_config_register), .fetch_address(fetch_address),
    .flash_read_data(flash_read_data));
  // ----------------
  // shared tasks
  // ----------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // single classic cycle; waits for ack, then one idle cycle
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                         output logic [31:0] rd);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    wb_sel_i <= 4'hf;
    @(posedge clk);
    while (wb_ack_o !== 1'b1) @(posedge clk);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic check_flags(input string what, input logic [4:0] exp);
    logic [31:0] rd;
    wb_xfer(1'b0, ADDR_STATUS, 32'h0, rd);
    check(what, {27'h0, exp}, {27'h0, rd[4:0]});
  endtask
  task automatic wait_core(input logic lvl, input int lim, input string what);
    int n;
    n = 0;
    while (core_reset_n !== lvl && n < lim) begin
      @(posedge clk);
      n++;
    end
    check(what, {31'h0, lvl}, {31'h0, core_reset_n});
  endtask
  task automatic end_init();
    end_of_init_instruction <= 1'b1;
    @(posedge clk);
    end_of_init_instruction <= 1'b0;
    check_flags("flags after end of init", 5'h00);
  endtask
  task automatic complete_run();
    if (mismatches == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_power_on();
    logic [31:0] rd;
    sup.power_release();
    wait_core(1'b1, 40, "core after power-on");
    check("config latched", {16'h0, straps}, {16'h0, system_config_register});
    check("fetch address", 32'h0, {8'h0, fetch_address});
    check("strobes idle", 32'h1, {31'h0, strobes_inactive});
    check_flags("power-on flags", FLAG_RESET);
    wb_xfer(1'b0, ADDR_CTRL, 32'h0, rd);
    check("bidir after power-on", 32'h0, {31'h0, rd[CTRL_BIDIR_BIT]});
    wb_xfer(1'b0, 8'h0c, 32'h0, rd);
    check("unmapped read", 32'h0, rd);
    end_init();
  endtask
  task automatic t_glitch();
    sup.hold_request(1'b1, 2);
    repeat (20) @(posedge clk);
    check("glitch ignored", 32'h1, {31'h0, reset_indication_out_n});
  endtask
  task automatic t_sync_short();
    sup.hold_request(1'b1, 100);
    repeat (300) @(posedge clk);
    check("core held in sequence", 32'h0, {31'h0, core_reset_n});
    wait_core(1'b1, 400, "core after short reset");
    check_flags("short flags", 5'b1 << FLAG_SHORT_BIT);
    end_init();
  endtask
  task automatic t_sync_long();
    sup.hold_request(1'b1, 700);
    wait_core(1'b1, 200, "core after long reset");
    check_flags("long flags", (5'b1 << FLAG_SHORT_BIT) | (5'b1 << FLAG_LONG_BIT));
    end_init();
  endtask
  task automatic t_bidir_wdt();
    logic [31:0] rd;
    wb_xfer(1'b1, ADDR_CTRL, 32'h1, rd);
    wb_xfer(1'b0, ADDR_CTRL, 32'h0, rd);
    check("bidir written", 32'h1, {31'h0, rd[CTRL_BIDIR_BIT]});
    watchdog_overflow <= 1'b1;
    @(posedge clk);
    watchdog_overflow <= 1'b0;
    wait_core(1'b0, 20, "core reset by watchdog");
    repeat (8) @(posedge clk);
    check("pin pulled by watchdog", 32'h1, {31'h0, reset_request_oe});
    check("pull level low", 32'h0, {31'h0, reset_request_out});
    wait_core(1'b1, 800, "core after watchdog");
    wb_xfer(1'b0, ADDR_STATUS, 32'h0, rd);
    check("watchdog flag", 32'h1, {31'h0, rd[FLAG_WDT_BIT]});
    wb_xfer(1'b0, ADDR_CTRL, 32'h0, rd);
    check("bidir after sequence", 32'h0, {31'h0, rd[CTRL_BIDIR_BIT]});
    end_init();
  endtask
  task automatic t_sw_mode_low();
    logic [31:0] rd;
    logic seen;
    int n;
    seen = 1'b0;
    n = 0;
    sup.set_pins(1'b0, 1'b0, straps);
    wb_xfer(1'b1, ADDR_CTRL, 32'h1, rd);
    software_reset_instruction <= 1'b1;
    @(posedge clk);
    software_reset_instruction <= 1'b0;
    wait_core(1'b0, 20, "core reset by software");
    while (core_reset_n !== 1'b1 && n < 800) begin
      @(posedge clk);
      seen = seen | reset_request_oe;
      n++;
    end
    check("no pull with mode low", 32'h0, {31'h0, seen});
    check_flags("software flag", 5'b1 << FLAG_SW_BIT);
    end_init();
  endtask
  task automatic t_async_flash();
    sup.set_pins(1'b0, 1'b1, 16'h5a3c);
    fork
      sup.hold_request(1'b0, 30);
      begin
        repeat (25) @(posedge clk);
        check("async indication", 32'h0, {31'h0, reset_indication_out_n});
        check("async tristate", 32'h1, {31'h0, bus_tristate});
      end
    join
    repeat (20) @(posedge clk);
    check("early flash data", 32'hffff, {16'h0, flash_read_data});
    repeat (80) @(posedge clk);
    check("late flash data", 32'h009b, {16'h0, flash_read_data});
    check("core waits flash", 32'h0, {31'h0, core_reset_n});
    flash_init_done <= 1'b1;
    wait_core(1'b1, 20, "core after flash done");
    flash_init_done <= 1'b0;
    check("config relatched", 32'h5a3c, {16'h0, system_config_register});
  endtask
  task automatic t_mode_fall();
    sup.set_pins(1'b1, 1'b0, 16'hc3a5);
    fork
      sup.hold_request(1'b1, 60);
      begin
        repeat (20) @(posedge clk);
        sup.set_pins(1'b0, 1'b0, 16'hc3a5);
      end
    join
    wait_core(1'b1, 40, "async exit after mode fall");
    check("config after mode fall", 32'hc3a5, {16'h0, system_config_register});
  endtask
  // ----------------
  // main sequence and watchdog
  // ----------------
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    t_power_on();
    t_glitch();
    t_sync_short();
    t_sync_long();
    t_bidir_wdt();
    t_sw_mode_low();
    t_async_flash();
    t_mode_fall();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run();
  end
endmodule
